// ===== src/odc_pkg.sv
// Constants, encodings and decode helpers for the OLED command decoder.
// Assumes a single 40 MHz core clock and byte-wide command traffic.
package odc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned ODC_CLK_HZ        = 40_000_000;
  localparam int unsigned ODC_ON_DELAY_MS   = 200;
  localparam int unsigned ODC_ON_DELAY_CYC  = ODC_ON_DELAY_MS * (ODC_CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] ODC_OP_COL_WIN   = 8'h15;
  localparam logic [7:0] ODC_OP_RAM_WR    = 8'h5C;
  localparam logic [7:0] ODC_OP_RAM_RD    = 8'h5D;
  localparam logic [7:0] ODC_OP_ROW_WIN   = 8'h75;
  localparam logic [7:0] ODC_OP_CON_A     = 8'h81;
  localparam logic [7:0] ODC_OP_CON_B     = 8'h82;
  localparam logic [7:0] ODC_OP_CON_C     = 8'h83;
  localparam logic [7:0] ODC_OP_MASTER    = 8'h87;
  localparam logic [7:0] ODC_OP_PRE2_SPD  = 8'h8A;
  localparam logic [7:0] ODC_OP_REMAP     = 8'hA0;
  localparam logic [7:0] ODC_OP_START     = 8'hA1;
  localparam logic [7:0] ODC_OP_OFFSET    = 8'hA2;
  localparam logic [7:0] ODC_OP_MODE_NORM = 8'hA4;
  localparam logic [7:0] ODC_OP_MODE_INV  = 8'hA7;
  localparam logic [7:0] ODC_OP_MUX       = 8'hA8;
  localparam logic [7:0] ODC_OP_DIM_CFG   = 8'hAB;
  localparam logic [7:0] ODC_OP_ON_DIM    = 8'hAC;
  localparam logic [7:0] ODC_OP_OFF       = 8'hAE;
  localparam logic [7:0] ODC_OP_ON_NORM   = 8'hAF;
  localparam logic [7:0] ODC_OP_PHASE     = 8'hB1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ODC_RST_COL_START = 8'h00;
  localparam logic [7:0] ODC_RST_COL_END   = 8'h9F;
  localparam logic [7:0] ODC_RST_ROW_START = 8'h00;
  localparam logic [7:0] ODC_RST_ROW_END   = 8'h83;
  localparam logic [7:0] ODC_RST_CONTRAST  = 8'h80;
  localparam logic [3:0] ODC_RST_MASTER    = 4'hF;
  localparam logic [1:0] ODC_RST_PRE2_SPD  = 2'h2;
  localparam logic [7:0] ODC_RST_REMAP     = 8'h40;
  localparam logic [7:0] ODC_RST_START     = 8'h00;
  localparam logic [7:0] ODC_RST_OFFSET    = 8'h00;
  localparam logic [1:0] ODC_RST_MODE      = 2'h0;
  localparam logic [7:0] ODC_RST_MUX       = 8'h83;
  localparam logic [7:0] ODC_RST_DIM_CON   = 8'h00;
  localparam logic [4:0] ODC_RST_DIM_PRE   = 5'h00;
  localparam logic [3:0] ODC_RST_PH1       = 4'h4;
  localparam logic [3:0] ODC_RST_PH2       = 4'h7;

  // ----------------------------------------------------------------
  // Field positions and limits
  // ----------------------------------------------------------------
  localparam int unsigned ODC_RMP_VERT     = 0;
  localparam int unsigned ODC_RMP_COL_REV  = 1;
  localparam int unsigned ODC_RMP_SUB_REV  = 2;
  localparam int unsigned ODC_RMP_LR_SWAP  = 3;
  localparam int unsigned ODC_RMP_SCAN_REV = 4;
  localparam int unsigned ODC_RMP_SPLIT    = 5;
  localparam int unsigned ODC_RMP_FMT_LO   = 6;
  localparam logic [1:0]  ODC_FMT_262K     = 2'h2;
  localparam logic [7:0]  ODC_MUX_MIN      = 8'h0F;
  localparam logic [3:0]  ODC_PH1_MIN      = 4'h1;
  localparam logic [3:0]  ODC_PH2_MIN      = 4'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ODC_ST_IDLE   = 2'b00,
    ODC_ST_PARAM  = 2'b01,
    ODC_ST_RAM_WR = 2'b10,
    ODC_ST_RAM_RD = 2'b11
  } odc_state_e;

  typedef enum logic [1:0] {
    ODC_DISP_OFF    = 2'b00,
    ODC_DISP_DIM    = 2'b01,
    ODC_DISP_NORMAL = 2'b10
  } odc_disp_e;

  // Parameter bytes each opcode expects; zero for single-byte ones
  function automatic logic [2:0] odc_param_count(input logic [7:0] op);
    case (op)
      ODC_OP_COL_WIN, ODC_OP_ROW_WIN:                      odc_param_count = 3'd2;
      ODC_OP_CON_A, ODC_OP_CON_B, ODC_OP_CON_C:            odc_param_count = 3'd1;
      ODC_OP_MASTER, ODC_OP_PRE2_SPD, ODC_OP_REMAP:        odc_param_count = 3'd1;
      ODC_OP_START, ODC_OP_OFFSET, ODC_OP_MUX:             odc_param_count = 3'd1;
      ODC_OP_PHASE:                                        odc_param_count = 3'd1;
      ODC_OP_DIM_CFG:                                      odc_param_count = 3'd5;
      default:                                             odc_param_count = 3'd0;
    endcase
  endfunction : odc_param_count

endpackage : odc_pkg

// ===== src/odc_pin_sync.sv
// Three-stage synchroniser for slow strap-like pins.
// Assumes the pin changes rarely; a change counts once stages two and three agree.
`timescale 1ns/1ps
module odc_pin_sync
  import odc_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // ----------------------------------------------------------------
  // Capture chain
  // ----------------------------------------------------------------
  // First stage feeds only the second; nothing else looks at it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta   <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      meta   <= pin;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  // Accept a bit only when the last two stages agree
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          level[gi] <= 1'b0;
        end else if (stage2[gi] == stage3[gi]) begin
          level[gi] <= stage3[gi];
        end
      end
    end
  endgenerate

endmodule : odc_pin_sync

// ===== src/odc_decoder.sv
// Command decoder and configuration store of an RGB dot-matrix OLED driver.
// Assumes host bytes arrive as one-cycle strobes on the core clock; the
// interface-width strap is an asynchronous pin. nrst is the hardware clear pin.
`timescale 1ns/1ps

// Notes on behaviour
// - 15h sets column window, reset 0 and 159.
// - 75h sets row window, reset 0 and 131.
// - 5Ch opens RAM writes, 5Dh opens RAM reads.
// - 81h-83h set colour contrasts, reset 80h.
// - 87h sets 4-bit master current, reset 0Fh.
// - 8Ah sets second pre-charge speed, reset normal.
// - Remap bit 0 picks vertical address increment.
// - Remap bits 1-3: column, subpixel, common swap.
// - Remap bits 4-5: reverse scan, odd/even split.
// - Remap bits 7:6 colour format, reset 65k.
// - Wide host interface forces 262k colour depth.
// - A1h sets start line, reset 0.
// - A2h sets vertical offset, reset 0.
// - A4h-A7h select display mode, reset normal.
// - A8h sets mux ratio; codes below 15 ignored.
// - ABh takes five bytes: reserved, contrasts, pre-charge.
// - ACh dim on, AEh off, AFh normal on.
// - B1h low nibble phase 1, 2n+1 clocks.
// - B1h high nibble phase 2, n clocks.
// - Drivers go active 200 ms after display on.
module odc_decoder
  import odc_pkg::*;
#(
  parameter int unsigned ON_DELAY_CYCLES = ODC_ON_DELAY_CYC
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       wr_strobe,
  input  wire logic       rd_strobe,
  input  wire logic       dc_sel,
  input  wire logic [7:0] wr_data,
  input  wire logic       wide_bus_pin,
  output logic      [7:0] col_start,
  output logic      [7:0] col_end,
  output logic      [7:0] row_start,
  output logic      [7:0] row_end,
  output logic            ram_write_mode,
  output logic            ram_read_mode,
  output logic            ram_wr_pulse,
  output logic      [7:0] ram_wr_byte,
  output logic            ram_rd_pulse,
  output logic      [7:0] contrast_a,
  output logic      [7:0] contrast_b,
  output logic      [7:0] contrast_c,
  output logic      [3:0] master_current,
  output logic      [1:0] precharge2_speed,
  output logic            addr_vertical,
  output logic            col_reverse,
  output logic            subpixel_reverse,
  output logic            com_lr_swap,
  output logic            com_scan_reverse,
  output logic            com_split,
  output logic      [1:0] color_format,
  output logic      [1:0] color_depth,
  output logic      [7:0] start_line,
  output logic      [7:0] display_offset,
  output logic      [1:0] display_mode,
  output logic      [7:0] mux_ratio,
  output logic      [7:0] dim_contrast_a,
  output logic      [7:0] dim_contrast_b,
  output logic      [7:0] dim_contrast_c,
  output logic      [4:0] dim_precharge,
  output logic      [1:0] display_state,
  output logic            drive_active,
  output logic      [3:0] phase1_code,
  output logic      [3:0] phase2_code,
  output logic      [4:0] phase1_clocks
);

  localparam int unsigned CW = $clog2(ON_DELAY_CYCLES + 1);
  localparam logic [CW-1:0] ON_TARGET = CW'(ON_DELAY_CYCLES);

  odc_state_e state;
  logic [7:0] opcode;
  logic [2:0] par_cnt;
  logic [7:0] par_buf [0:3];
  logic [CW-1:0] on_count;
  logic       wide_bus;
  logic       cmd_take;
  logic       par_take;
  logic [2:0] need;
  logic       apply;

  // ----------------------------------------------------------------
  // Strap synchroniser
  // ----------------------------------------------------------------
  odc_pin_sync #(
    .WIDTH (1)
  ) u_wide_sync (
    .clock (clock),
    .nrst  (nrst),
    .pin   (wide_bus_pin),
    .level (wide_bus)
  );

  // ----------------------------------------------------------------
  // Byte classification
  // ----------------------------------------------------------------
  // Select low marks an opcode, high a parameter or pixel byte
  assign cmd_take = wr_strobe & ~dc_sel;
  assign par_take = wr_strobe & dc_sel;
  assign need     = odc_param_count(opcode);
  // Last expected byte commits the whole setting at once
  assign apply    = par_take && (state == ODC_ST_PARAM) && (par_cnt == need - 3'd1);

  // ----------------------------------------------------------------
  // Decode sequencer
  // ----------------------------------------------------------------
  // A new opcode always restarts decoding, so a short command aborts cleanly
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state   <= ODC_ST_IDLE;
      opcode  <= 8'h00;
      par_cnt <= 3'd0;
    end else if (cmd_take) begin
      opcode  <= wr_data;
      par_cnt <= 3'd0;
      case (wr_data)
        ODC_OP_RAM_WR: state <= ODC_ST_RAM_WR;
        ODC_OP_RAM_RD: state <= ODC_ST_RAM_RD;
        default: begin
          state <= (odc_param_count(wr_data) != 3'd0) ? ODC_ST_PARAM : ODC_ST_IDLE;
        end
      endcase
    end else if (par_take && state == ODC_ST_PARAM) begin
      if (apply) begin
        state   <= ODC_ST_IDLE;
        par_cnt <= 3'd0;
      end else begin
        par_cnt <= par_cnt + 3'd1;
      end
    end
  end

  // Early parameter bytes wait here until the last one arrives
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        par_buf[i] <= 8'h00;
      end
    end else if (par_take && state == ODC_ST_PARAM && !apply) begin
      par_buf[par_cnt[1:0]] <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // RAM access stream
  // ----------------------------------------------------------------
  assign ram_write_mode = (state == ODC_ST_RAM_WR);
  assign ram_read_mode  = (state == ODC_ST_RAM_RD);

  // Pixel bytes pass one per strobe; no buffering beyond one stage
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ram_wr_pulse <= 1'b0;
      ram_wr_byte  <= 8'h00;
      ram_rd_pulse <= 1'b0;
    end else begin
      ram_wr_pulse <= par_take && (state == ODC_ST_RAM_WR);
      ram_rd_pulse <= rd_strobe && dc_sel && (state == ODC_ST_RAM_RD);
      if (par_take && state == ODC_ST_RAM_WR) begin
        ram_wr_byte <= wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Access window
  // ----------------------------------------------------------------
  // Range is left to the host; addresses are stored as sent
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      col_start <= ODC_RST_COL_START;
      col_end   <= ODC_RST_COL_END;
      row_start <= ODC_RST_ROW_START;
      row_end   <= ODC_RST_ROW_END;
    end else if (apply && opcode == ODC_OP_COL_WIN) begin
      col_start <= par_buf[0];
      col_end   <= wr_data;
    end else if (apply && opcode == ODC_OP_ROW_WIN) begin
      row_start <= par_buf[0];
      row_end   <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Current settings
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      contrast_a       <= ODC_RST_CONTRAST;
      contrast_b       <= ODC_RST_CONTRAST;
      contrast_c       <= ODC_RST_CONTRAST;
      master_current   <= ODC_RST_MASTER;
      precharge2_speed <= ODC_RST_PRE2_SPD;
    end else if (apply) begin
      case (opcode)
        ODC_OP_CON_A:    contrast_a       <= wr_data;
        ODC_OP_CON_B:    contrast_b       <= wr_data;
        ODC_OP_CON_C:    contrast_c       <= wr_data;
        ODC_OP_MASTER:   master_current   <= wr_data[3:0];
        ODC_OP_PRE2_SPD: precharge2_speed <= wr_data[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Remap and colour format
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      addr_vertical    <= ODC_RST_REMAP[ODC_RMP_VERT];
      col_reverse      <= ODC_RST_REMAP[ODC_RMP_COL_REV];
      subpixel_reverse <= ODC_RST_REMAP[ODC_RMP_SUB_REV];
      com_lr_swap      <= ODC_RST_REMAP[ODC_RMP_LR_SWAP];
      com_scan_reverse <= ODC_RST_REMAP[ODC_RMP_SCAN_REV];
      com_split        <= ODC_RST_REMAP[ODC_RMP_SPLIT];
      color_format     <= ODC_RST_REMAP[ODC_RMP_FMT_LO +: 2];
    end else if (apply && opcode == ODC_OP_REMAP) begin
      addr_vertical    <= wr_data[ODC_RMP_VERT];
      col_reverse      <= wr_data[ODC_RMP_COL_REV];
      subpixel_reverse <= wr_data[ODC_RMP_SUB_REV];
      com_lr_swap      <= wr_data[ODC_RMP_LR_SWAP];
      com_scan_reverse <= wr_data[ODC_RMP_SCAN_REV];
      com_split        <= wr_data[ODC_RMP_SPLIT];
      color_format     <= wr_data[ODC_RMP_FMT_LO +: 2];
    end
  end

  // Wide pixel buses only carry 18-bit pixels, so depth is pinned
  assign color_depth = wide_bus ? ODC_FMT_262K : color_format;

  // ----------------------------------------------------------------
  // Scan geometry
  // ----------------------------------------------------------------
  // Short mux codes would starve the scan, so they are dropped
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      start_line     <= ODC_RST_START;
      display_offset <= ODC_RST_OFFSET;
      mux_ratio      <= ODC_RST_MUX;
    end else if (apply) begin
      case (opcode)
        ODC_OP_START:  start_line     <= wr_data;
        ODC_OP_OFFSET: display_offset <= wr_data;
        ODC_OP_MUX: begin
          if (wr_data >= ODC_MUX_MIN) begin
            mux_ratio <= wr_data;
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Display mode and power state
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      display_mode <= ODC_RST_MODE;
    end else if (cmd_take && wr_data >= ODC_OP_MODE_NORM && wr_data <= ODC_OP_MODE_INV) begin
      display_mode <= wr_data[1:0];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      display_state <= ODC_DISP_OFF;
    end else if (cmd_take) begin
      case (wr_data)
        ODC_OP_ON_DIM:  display_state <= ODC_DISP_DIM;
        ODC_OP_OFF:     display_state <= ODC_DISP_OFF;
        ODC_OP_ON_NORM: display_state <= ODC_DISP_NORMAL;
        default: ;
      endcase
    end
  end

  // Drivers wait out the turn-on delay; sleep drops them at once, the count clears one cycle later
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      on_count <= '0;
    end else if (display_state == ODC_DISP_OFF) begin
      on_count <= '0;
    end else if (on_count != ON_TARGET) begin
      on_count <= on_count + CW'(1);
    end
  end

  assign drive_active = (display_state != ODC_DISP_OFF) && (on_count == ON_TARGET);

  // ----------------------------------------------------------------
  // Dim mode settings
  // ----------------------------------------------------------------
  // Byte 0 is reserved and discarded
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dim_contrast_a <= ODC_RST_DIM_CON;
      dim_contrast_b <= ODC_RST_DIM_CON;
      dim_contrast_c <= ODC_RST_DIM_CON;
      dim_precharge  <= ODC_RST_DIM_PRE;
    end else if (apply && opcode == ODC_OP_DIM_CFG) begin
      dim_contrast_a <= par_buf[1];
      dim_contrast_b <= par_buf[2];
      dim_contrast_c <= par_buf[3];
      dim_precharge  <= wr_data[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Drive phase periods
  // ----------------------------------------------------------------
  // Each nibble is checked on its own; an invalid nibble keeps its old value
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase1_code <= ODC_RST_PH1;
      phase2_code <= ODC_RST_PH2;
    end else if (apply && opcode == ODC_OP_PHASE) begin
      if (wr_data[3:0] >= ODC_PH1_MIN) begin
        phase1_code <= wr_data[3:0];
      end
      if (wr_data[7:4] >= ODC_PH2_MIN) begin
        phase2_code <= wr_data[7:4];
      end
    end
  end

  assign phase1_clocks = {phase1_code, 1'b1};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  chk_col_window: assert property (
    (par_take && state == ODC_ST_PARAM && opcode == ODC_OP_COL_WIN && par_cnt == 3'd1)
      |=> (col_start == $past(par_buf[0]) && col_end == $past(wr_data)))
    else $error("column window not applied from both bytes");

  chk_row_wait: assert property (
    (par_take && state == ODC_ST_PARAM && opcode == ODC_OP_ROW_WIN && par_cnt == 3'd0)
      |=> ($stable(row_start) && $stable(row_end) && par_cnt == 3'd1))
    else $error("row window changed before last byte");

  chk_contrast_b: assert property (
    (apply && opcode == ODC_OP_CON_B)
      |=> (contrast_b == $past(wr_data) && $stable(contrast_a) && $stable(contrast_c)))
    else $error("contrast B not stored alone");

  chk_depth_forced: assert property (
    wide_bus |-> color_depth == ODC_FMT_262K)
    else $error("wide bus did not force 262k depth");

  chk_mux_invalid: assert property (
    (apply && opcode == ODC_OP_MUX && wr_data < ODC_MUX_MIN) |=> $stable(mux_ratio))
    else $error("invalid mux code accepted");

  chk_dim_five: assert property (
    (apply && opcode == ODC_OP_DIM_CFG)
      |-> (par_cnt == 3'd4) ##1 (dim_precharge == $past(wr_data[4:0])
          && dim_contrast_c == $past(par_buf[3])))
    else $error("dim settings not taken from fifth byte");

  chk_display_on: assert property (
    (cmd_take && wr_data == ODC_OP_ON_NORM)
      |=> (display_state == ODC_DISP_NORMAL && display_mode == $past(display_mode)))
    else $error("normal on not entered");

  chk_sleep_drop: assert property (
    (cmd_take && wr_data == ODC_OP_OFF) |=> !drive_active ##1 (on_count == '0))
    else $error("drivers stay active after sleep");

  chk_drive_early: assert property (
    $rose(drive_active) |-> ($past(on_count) == ON_TARGET - CW'(1)
      && $past(display_state) != ODC_DISP_OFF))
    else $error("drivers activated before the delay");

  chk_phase_invalid: assert property (
    (apply && opcode == ODC_OP_PHASE && wr_data[3:0] == 4'h0)
      |=> ($stable(phase1_code) && phase1_clocks == {$past(phase1_code), 1'b1}))
    else $error("invalid phase 1 code accepted");

  chk_phase2_store: assert property (
    (apply && opcode == ODC_OP_PHASE && wr_data[7:4] >= ODC_PH2_MIN)
      |=> phase2_code == $past(wr_data[7:4]))
    else $error("phase 2 code not stored");

  chk_ram_stream: assert property (
    (par_take && state == ODC_ST_RAM_WR)
      |=> (ram_wr_pulse && ram_wr_byte == $past(wr_data)) ##1 (!ram_wr_pulse || $past(par_take)))
    else $error("pixel byte not forwarded");

endmodule : odc_decoder

// ===== tb/odc_host.sv
// Host model: one byte per write strobe on the core clock.
// Assumes the bench calls send; bytes go out two cycles apart.
`timescale 1ns/1ps
module odc_host (
  input  wire logic       clock,
  output logic            wr_strobe,
  output logic            dc_sel,
  output logic      [7:0] wr_data
);
  // ----------------
  // Byte transfer
  // ----------------
  initial begin
    wr_strobe = 1'b0;
    dc_sel    = 1'b0;
    wr_data   = 8'h00;
  end
  // Released data inverts so a stale byte cannot pass
  task automatic send(input logic dc, input logic [7:0] b);
    @(posedge clock);
    wr_strobe <= 1'b1;
    dc_sel    <= dc;
    wr_data   <= b;
    @(posedge clock);
    wr_strobe <= 1'b0;
    wr_data   <= ~b;
  endtask : send
endmodule : odc_host

// ===== tb/testbench.sv
// Self-checking bench for the decoder: random and corner commands.
// Assumes odc_host owns the byte port; turn-on delay is shortened.
`timescale 1ns/1ps
module testbench;
  import odc_pkg::*;
  localparam int DLY = 20;
  logic       clock, nrst, rd_strobe, wide_bus_pin, wr_strobe, dc_sel, drive_active;
  logic       ram_write_mode, ram_read_mode, ram_wr_pulse, ram_rd_pulse, com_split;
  logic       addr_vertical, col_reverse, subpixel_reverse, com_lr_swap, com_scan_reverse;
  logic [1:0] precharge2_speed, color_format, color_depth, display_mode, display_state;
  logic [3:0] master_current, phase1_code, phase2_code, p1, p2;
  logic [4:0] dim_precharge, phase1_clocks;
  logic [7:0] wr_data, col_start, col_end, row_start, row_end, ram_wr_byte, r, c, w;
  logic [7:0] contrast_a, contrast_b, contrast_c, start_line, display_offset, mux_ratio;
  logic [7:0] dim_contrast_a, dim_contrast_b, dim_contrast_c;
  int         seed, err_total, num_checks, i;
  // ----------------
  // Harness
  // ----------------
  wire [31:0] win = {col_start, col_end, row_start, row_end};
  wire [31:0] lvl = {contrast_a, contrast_b, contrast_c, master_current, 2'b0, precharge2_speed};
  wire [31:0] geo = {start_line, display_offset, mux_ratio, phase2_code, phase1_code};
  wire [7:0]  rmp = {color_format, com_split, com_scan_reverse, com_lr_swap,
                     subpixel_reverse, col_reverse, addr_vertical};
  odc_host host (.clock(clock), .wr_strobe(wr_strobe), .dc_sel(dc_sel), .wr_data(wr_data));
  odc_decoder #(.ON_DELAY_CYCLES(DLY)) dut (.*);
  // Free-running core clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  function automatic logic [1:0] exp_depth(input logic wb, input logic [1:0] f);
    return wb ? 2'b10 : f;
  endfunction : exp_depth
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask : settle
  task automatic cmd1(input logic [7:0] op, input logic [7:0] p);
    host.send(1'b0, op);
    host.send(1'b1, p);
    settle();
  endtask : cmd1
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Main sequence: reset values, corners, then random rounds
  initial begin
    {nrst, rd_strobe, wide_bus_pin, err_total, num_checks, seed} = {3'b0, 64'd0, 32'd35};
    {p1, p2} = 8'h47;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    settle();
    chk("win", win, 32'h009F0083);
    chk("lvl", lvl, 32'h808080F2);
    chk("rmp", rmp, 8'h40);
    chk("geo", geo, 32'h00008374);
    chk("st", {display_mode, display_state, drive_active}, 0);
    cmd1(ODC_OP_MUX, 8'd14);
    chk("mux", mux_ratio, 8'h83);
    cmd1(ODC_OP_MUX, 8'd15);
    chk("mux", mux_ratio, 8'h0F);
    host.send(1'b0, ODC_OP_ROW_WIN);
    host.send(1'b1, 8'h05);
    cmd1(ODC_OP_CON_A, 8'h33);
    chk("abort", win, 32'h009F0083);
    for (i = 0; i < 6; i++) begin
      r = (i == 0) ? 8'h10 : 8'($random(seed));
      c = r % 8'd160;
      w = r % 8'd132;
      cmd1(ODC_OP_CON_A, r);
      cmd1(ODC_OP_CON_B, ~r);
      cmd1(ODC_OP_CON_C, r ^ 8'hA5);
      cmd1(ODC_OP_MASTER, r);
      cmd1(ODC_OP_PRE2_SPD, r);
      chk("lvl", lvl, {r, ~r, r ^ 8'hA5, r[3:0], 2'b0, r[1:0]});
      cmd1(ODC_OP_REMAP, r);
      chk("rmp", rmp, r);
      chk("dep", color_depth, exp_depth(1'b0, r[7:6]));
      host.send(1'b0, ODC_OP_COL_WIN);
      host.send(1'b1, c);
      host.send(1'b1, 8'd159 - c);
      cmd1(ODC_OP_ROW_WIN, w);
      host.send(1'b1, 8'd131 - w);
      cmd1(ODC_OP_ROW_WIN, r);
      cmd1(8'hFF, 8'd131 - w);
      chk("win", win, {c, 8'd159 - c, w, 8'd131 - w});
      cmd1(ODC_OP_START, w);
      cmd1(ODC_OP_OFFSET, 8'd131 - w);
      cmd1(ODC_OP_PHASE, r);
      if (r[3:0] != 4'h0) p1 = r[3:0];
      if (r[7:4] > 4'h1) p2 = r[7:4];
      chk("geo", geo, {w, 8'd131 - w, 8'h0F, p2, p1});
      chk("ph1", phase1_clocks, 2 * p1 + 1);
      cmd1(ODC_OP_DIM_CFG, 8'h00);
      for (int k = 0; k < 4; k++) host.send(1'b1, (k == 0) ? w : (k == 2) ? r ^ 8'h5A : ~r);
      settle();
      chk("dim", {dim_contrast_a, dim_contrast_b, dim_contrast_c, dim_precharge},
          {w, ~r, r ^ 8'h5A, ~r[4:0]});
      host.send(1'b0, ODC_OP_MODE_NORM | {6'h00, i[1:0]});
      settle();
      chk("mode", display_mode, i[1:0]);
    end
    wide_bus_pin <= 1'b1;
    repeat (6) @(posedge clock);
    #1;
    chk("dep", color_depth, exp_depth(1'b1, r[7:6]));
    host.send(1'b0, ODC_OP_ON_NORM);
    for (i = 0; i < 3 * DLY && drive_active !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    chk("dly", {i >= DLY && i <= DLY + 2, display_state}, 3'b110);
    host.send(1'b0, ODC_OP_ON_DIM);
    settle();
    chk("dimon", display_state, 2'd1);
    host.send(1'b0, ODC_OP_OFF);
    settle();
    chk("off", {display_state, drive_active}, 0);
    host.send(1'b0, ODC_OP_RAM_WR);
    host.send(1'b1, r);
    #1;
    for (i = 0; i < 4 && ram_wr_pulse !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    chk("ram", {ram_write_mode, ram_wr_pulse, ram_wr_byte}, {2'b11, r});
    host.send(1'b0, ODC_OP_RAM_RD);
    settle();
    chk("rd", {ram_write_mode, ram_read_mode}, 2'b01);
    host.send(1'b1, r);
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1;
    chk("rdp", ram_rd_pulse, 1'b1);
    @(posedge clock);
    #1;
    chk("rdp", ram_rd_pulse, 1'b0);
    nrst <= 1'b0;
    @(posedge clock);
    #1;
    chk("rst", {win, rmp}, 40'h009F008340);
    tally_and_finish();
  end
endmodule : testbench
